// ---- rtl/ext_ctl_two_pkg.sv ----
// Purpose: Shared constants for the second extended control register.
// Assumes: 5-bit management register address, 16-bit register data.
// Notes:   Interrupt status and mask registers sit beside the control one.
package ext_ctl_two_pkg;

  // Bus widths
  localparam int ADDR_W  = 5;
  localparam int DATA_W  = 16;
  localparam int NUM_LED = 5;   // Shared address-strap / LED pins
  localparam int IRQ_W   = 2;   // Interrupt event count

  // Register offsets
  localparam logic [ADDR_W-1:0] REG_EXT_CTL2 = 5'h13;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 5'h1C;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 5'h1D;

  // Field positions of the control register
  localparam int BIT_NODE_REP  = 15;  // Read-only strap level
  localparam int BIT_PRIORITY  = 14;  // Read-only strap level
  localparam int BIT_RFAULT    = 13;  // Read-only partner fault
  localparam int BIT_RSVD_RO   = 10;  // Read-only reserved, reads zero
  localparam int BIT_TX_FLOAT  = 7;   // Transmit outputs float
  localparam int BIT_FORCE_LED = 5;   // All LEDs on
  localparam int BIT_AUTO_PD   = 0;   // 100 Mb/s power-down in 10 Mb/s

  // Bits that software may store (all read-write, reserved included)
  localparam logic [DATA_W-1:0] CTL_RW_MASK = 16'h1BFF;
  // Stored reset value of the read-write bits
  localparam logic [DATA_W-1:0] CTL_RESET   = 16'h0001;

  // Interrupt event positions
  localparam int IRQ_RF_SET = 0;  // Partner fault appeared
  localparam int IRQ_RF_CLR = 1;  // Partner fault went away
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // Reset must cover the synchroniser plus one edge
  localparam int SYNC_STAGES  = 2;
  localparam int RESET_CYCLES = SYNC_STAGES + 1;

endpackage

// ---- rtl/strap_led_if.sv ----
// Purpose: Carrier between register core and strap/LED pin driver.
// Assumes: Both ends on the same clock.
// Notes:   Strap values are stable once straps_valid is high.
`timescale 1ns/10ps
interface strap_led_if #(
  parameter int N = 5
);
  logic         straps_valid;  // Straps captured, LEDs driving
  logic         node_repeater; // Captured node/repeater strap
  logic         reg_priority;  // Captured priority strap
  logic [N-1:0] led_sense;     // Captured level of shared pins
  logic         force_on;      // Diagnostic all-on request
  logic [N-1:0] led_status;    // Normal indication, high = on

  modport pins (output straps_valid, output node_repeater,
                output reg_priority, output led_sense,
                input force_on, input led_status);
  modport core (input straps_valid, input node_repeater,
                input reg_priority, input led_sense,
                output force_on, output led_status);
endinterface

// ---- rtl/strap_led_driver.sv ----
// Purpose: Samples strap pins at reset exit and drives shared LED pins.
// Assumes: rst_n held low for at least RESET_CYCLES edges.
// Notes:   Synchroniser stages keep running through reset on purpose.
`timescale 1ns/10ps
module strap_led_driver
  import ext_ctl_two_pkg::*;
#(
  parameter int N = NUM_LED
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         node_repeater_strap,
  input  wire logic         pin_or_register_priority_strap,
  input  wire logic [N-1:0] led_pin_in,
  output logic      [N-1:0] led_pin_out,
  output logic      [N-1:0] led_pin_oe,
  strap_led_if.pins         sl
);

  // Sampling phase, then LED drive phase
  typedef enum logic {
    PH_SAMPLE = 1'b0,
    PH_DRIVE  = 1'b1
  } phase_e;

  typedef struct packed {
    logic [N+1:0] sync1;  // First synchroniser stage
    logic [N+1:0] sync2;  // Second synchroniser stage
    logic [N+1:0] caught; // Captured strap levels
    phase_e       phase;  // Current phase
    logic [N-1:0] drive;  // Registered pin output levels
  } drv_state_s;

  drv_state_s st_r;  // Current state
  drv_state_s st_nxt; // Next state

  // Reset is folded in here so the synchroniser keeps tracking pins
  always_comb begin
    st_nxt       = st_r;
    st_nxt.sync1 = {node_repeater_strap, pin_or_register_priority_strap, led_pin_in};
    st_nxt.sync2 = st_r.sync1;
    if (!rst_n) begin
      // Pins are inputs; nothing captured yet
      st_nxt.caught = '0;
      st_nxt.phase  = PH_SAMPLE;
      st_nxt.drive  = '0;
    end else begin
      unique case (st_r.phase)
        PH_SAMPLE: begin
          // First edge after release: sync2 still holds reset-time levels
          st_nxt.caught = st_r.sync2;
          st_nxt.phase  = PH_DRIVE;
          // Enables rise now, so start at the off level: no one-cycle flash
          st_nxt.drive  = st_r.sync2[N-1:0];
        end
        PH_DRIVE: begin
          // On level is inverse of captured sense; force overrides
          for (int i = 0; i < N; i++) begin
            st_nxt.drive[i] = (sl.force_on | sl.led_status[i])
                              ? ~st_r.caught[i] : st_r.caught[i];
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clock) begin
    st_r <= st_nxt;
  end

  // Pins stay inputs until the sense is known
  assign led_pin_oe       = {N{st_r.phase == PH_DRIVE}};
  assign led_pin_out      = st_r.drive;
  assign sl.straps_valid  = (st_r.phase == PH_DRIVE);
  assign sl.node_repeater = st_r.caught[N+1];
  assign sl.reg_priority  = st_r.caught[N];
  assign sl.led_sense     = st_r.caught[N-1:0];

endmodule // strap_led_driver

// ---- rtl/phy_extended_control_two.sv ----
// Purpose: Second extended control and status register of the PHY.
// Assumes: Single 20 MHz clock, synchronous active-low reset.
// Notes:   Straps and LED pins are handled by strap_led_driver.
`timescale 1ns/10ps
module phy_extended_control_two
  import ext_ctl_two_pkg::*;
#(
  parameter int N = NUM_LED
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [DATA_W-1:0] reg_rdata,
  // Interrupt
  output logic                   irq,
  // Configuration straps
  input  wire logic              node_repeater_strap,
  input  wire logic              pin_or_register_priority_strap,
  // Shared address-strap / LED pins
  input  wire logic [N-1:0]      led_pin_in,
  output logic      [N-1:0]      led_pin_out,
  output logic      [N-1:0]      led_pin_oe,
  input  wire logic [N-1:0]      led_status,
  output logic      [N-1:0]      phy_address,
  // Link side, same clock
  input  wire logic              partner_remote_fault,
  input  wire logic              link_is_10base_t,
  input  wire logic              tx_activity,
  input  wire logic              rx_activity,
  output logic                   carrier_sense,
  output logic                   sqe_test_default,
  // Twisted-pair transmit data and drivers
  input  wire logic              tx_positive_data,
  input  wire logic              tx_negative_data,
  output logic                   pair_tx_positive,
  output logic                   pair_tx_positive_oe,
  output logic                   pair_tx_negative,
  output logic                   pair_tx_negative_oe,
  // Transceiver power control
  output logic                   tx100_power_down
);

  // Whole state of the core in one word
  typedef struct packed {
    logic [DATA_W-1:0] ctl;     // Stored read-write bits
    logic              rfault;  // Registered partner fault
    logic [IRQ_W-1:0]  stat;    // Sticky interrupt status
    logic [IRQ_W-1:0]  mask;    // Interrupt enables
    logic [DATA_W-1:0] rdata;   // Read data, one cycle after strobe
    logic              crs;     // Carrier sense
    logic              pd;      // 100 Mb/s power-down
    logic              txp;     // Positive transmit level
    logic              txn;     // Negative transmit level
  } core_state_s;

  // Reset image; only the stored control bits are not zero
  localparam core_state_s CORE_RESET = '{
    ctl:    CTL_RESET,
    stat:   IRQ_RESET,
    mask:   IRQ_RESET,
    default: '0
  };

  core_state_s st_r;   // Current state
  core_state_s st_nxt; // Next state

  // Carrier between core and pin driver
  strap_led_if #(.N(N)) sl ();

  // Pin driver: strap capture and LED outputs
  strap_led_driver #(.N(N)) u_pins (
    .clock                          (clock),
    .rst_n                          (rst_n),
    .node_repeater_strap            (node_repeater_strap),
    .pin_or_register_priority_strap (pin_or_register_priority_strap),
    .led_pin_in                     (led_pin_in),
    .led_pin_out                    (led_pin_out),
    .led_pin_oe                     (led_pin_oe),
    .sl                             (sl)
  );

  // Address decode helper, used for every register
  function automatic logic hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] offset
  );
    hit = (addr == offset);
  endfunction

  // Full 16-bit image of the control register as software sees it
  function automatic logic [DATA_W-1:0] ctl_image(
    input logic [DATA_W-1:0] stored,
    input logic              node_rep,
    input logic              prio,
    input logic              rfault
  );
    logic [DATA_W-1:0] v;
    v = stored & CTL_RW_MASK;
    v[BIT_NODE_REP] = node_rep;
    v[BIT_PRIORITY] = prio;
    v[BIT_RFAULT]   = rfault;
    v[BIT_RSVD_RO]  = 1'b0;
    ctl_image = v;
  endfunction

  // Decoded strobes
  logic wr_ctl;   // Write to control register
  logic wr_stat;  // Write-one-to-clear status
  logic wr_mask;  // Write to mask

  // Strobe decode is plain combinational logic
  assign wr_ctl  = reg_write & hit(reg_addr, REG_EXT_CTL2);
  assign wr_stat = reg_write & hit(reg_addr, REG_IRQ_STAT);
  assign wr_mask = reg_write & hit(reg_addr, REG_IRQ_MASK);

  // Partner-fault edges raise interrupt events
  logic [IRQ_W-1:0] events;

  // Events come from the registered copy so each edge is one pulse
  always_comb begin
    events             = '0;
    events[IRQ_RF_SET] = partner_remote_fault & ~st_r.rfault;
    events[IRQ_RF_CLR] = ~partner_remote_fault & st_r.rfault;
  end

  // Node mode comes from the captured strap
  logic node_mode;
  assign node_mode = ~sl.node_repeater;

  // Next-state logic for the whole core
  always_comb begin
    st_nxt = st_r;

    // Control register write
    if (wr_ctl) begin
      // Read-only bits dropped, reserved read-write bits kept
      st_nxt.ctl = reg_wdata & CTL_RW_MASK;
    end

    // Mask register write
    if (wr_mask) begin
      st_nxt.mask = reg_wdata[IRQ_W-1:0];
    end

    // Sticky status: a new event wins over a clear in the same cycle
    if (wr_stat) begin
      st_nxt.stat = (st_r.stat & ~reg_wdata[IRQ_W-1:0]) | events;
    end else begin
      st_nxt.stat = st_r.stat | events;
    end

    // Partner fault follows the link word receiver
    st_nxt.rfault = partner_remote_fault;

    // Read data stands only in the cycle after the strobe
    st_nxt.rdata = '0;
    if (reg_read) begin
      if (hit(reg_addr, REG_EXT_CTL2)) begin
        // Live image, straps and fault included
        st_nxt.rdata = ctl_image(st_r.ctl, sl.node_repeater,
                                 sl.reg_priority, st_r.rfault);
      end else if (hit(reg_addr, REG_IRQ_STAT)) begin
        st_nxt.rdata = {{(DATA_W-IRQ_W){1'b0}}, st_r.stat};
      end else if (hit(reg_addr, REG_IRQ_MASK)) begin
        st_nxt.rdata = {{(DATA_W-IRQ_W){1'b0}}, st_r.mask};
      end else begin
        // Unmapped offsets read as zero
        st_nxt.rdata = '0;
      end
    end

    // Carrier sense: node counts own transmit, repeater does not
    if (node_mode) begin
      st_nxt.crs = tx_activity | rx_activity;
    end else begin
      st_nxt.crs = rx_activity;
    end

    // Power-down only while running 10 Mb/s with the bit set
    st_nxt.pd = st_r.ctl[BIT_AUTO_PD] & link_is_10base_t;

    // Transmit levels pass through one flop to match the enables
    st_nxt.txp = tx_positive_data;
    st_nxt.txn = tx_negative_data;
  end

  // State register with synchronous reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r <= CORE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Diagnostic request and normal indication to the pin driver
  assign sl.force_on   = st_r.ctl[BIT_FORCE_LED];
  assign sl.led_status = led_status;

  // Register read port
  assign reg_rdata = st_r.rdata;

  // Level interrupt while any unmasked status bit is set
  assign irq = |(st_r.stat & st_r.mask);

  // Captured address straps for the management decoder
  assign phy_address = sl.led_sense;

  // Link-side outputs
  assign carrier_sense    = st_r.crs;
  // SQE test default enabled only in node mode
  assign sqe_test_default = node_mode;
  assign tx100_power_down = st_r.pd;

  // Both transmit drivers released together when floating
  assign pair_tx_positive    = st_r.txp;
  assign pair_tx_negative    = st_r.txn;
  assign pair_tx_positive_oe = ~st_r.ctl[BIT_TX_FLOAT];
  assign pair_tx_negative_oe = ~st_r.ctl[BIT_TX_FLOAT];

endmodule // phy_extended_control_two

// ---- bench/phy_ext_ctl_two_assertions.sv ----
// Purpose: Port checks of the second extended control register.
// Assumes: Straps only move while rst_n is low.
// Notes:   Sees top ports only; bound after the module.
`timescale 1ns/10ps
module phy_ext_ctl_two_checker
  import ext_ctl_two_pkg::*;
#(
  parameter int N = NUM_LED
) (
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_write,
  input wire logic              reg_read,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              irq,
  input wire logic              node_repeater_strap,
  input wire logic              pin_or_register_priority_strap,
  input wire logic [N-1:0]      led_pin_out,
  input wire logic [N-1:0]      led_pin_oe,
  input wire logic [N-1:0]      led_status,
  input wire logic [N-1:0]      phy_address,
  input wire logic              partner_remote_fault,
  input wire logic              link_is_10base_t,
  input wire logic              tx_activity,
  input wire logic              rx_activity,
  input wire logic              carrier_sense,
  input wire logic              sqe_test_default,
  input wire logic              pair_tx_positive_oe,
  input wire logic              pair_tx_negative_oe,
  input wire logic              tx100_power_down
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Bus cycles aimed at the control register
  wire ctl_wr = reg_write && reg_addr == REG_EXT_CTL2;
  wire ctl_rd = reg_read && reg_addr == REG_EXT_CTL2;
  // Any decoded address; the rest must read zero
  wire mapped = reg_addr inside {REG_EXT_CTL2, REG_IRQ_STAT, REG_IRQ_MASK};

  strap_bits_a: assert property ($past(ctl_rd) |-> reg_rdata[15] == node_repeater_strap
    && reg_rdata[14] == pin_or_register_priority_strap && !reg_rdata[10])
    else $error("strap or reserved bit wrong on read");
  fault_bit_a: assert property ($past(ctl_rd) |-> reg_rdata[13] == $past(partner_remote_fault, 2))
    else $error("remote fault bit not mirrored");
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == '0)
    else $error("read data outside read cycle");
  unmapped_zero_a: assert property ($past(reg_read && !mapped) |-> reg_rdata == '0)
    else $error("unmapped read not zero");
  tx_float_a: assert property (ctl_wr |=> pair_tx_positive_oe == !$past(reg_wdata[7])
    && pair_tx_negative_oe == !$past(reg_wdata[7])) else $error("transmit float wrong");
  power_down_a: assert property (ctl_wr ##1 1 |=> tx100_power_down ==
    ($past(reg_wdata[BIT_AUTO_PD], 2) && $past(link_is_10base_t))) else $error("power-down wrong");
  carrier_rx_a: assert property ($past(rx_activity) |-> carrier_sense)
    else $error("carrier missing on receive");
  carrier_idle_a: assert property (!$past(rx_activity || tx_activity) |-> !carrier_sense)
    else $error("carrier without activity");
  sqe_mode_a: assert property (&led_pin_oe |-> sqe_test_default == !node_repeater_strap)
    else $error("SQE default does not follow mode");
  led_invert_a: assert property (&led_pin_oe && $past(&led_pin_oe) |->
    ((led_pin_out ^ phy_address) & $past(led_status)) == $past(led_status))
    else $error("LED on level not inverted");
  force_leds_a: assert property (ctl_wr && reg_wdata[5] && &led_pin_oe ##1 1 |=>
    led_pin_out == ~phy_address) else $error("forced LEDs not on");

  // Main scenarios reached
  cover property (ctl_wr ##1 ctl_rd);
  cover property ($rose(irq));
  cover property (rx_activity && !tx_activity ##1 carrier_sense);
endmodule // phy_ext_ctl_two_checker

bind phy_extended_control_two phy_ext_ctl_two_checker #(.N(N)) u_phy_ext_ctl_two_checker (
  .clock, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq,
  .node_repeater_strap, .pin_or_register_priority_strap, .led_pin_out, .led_pin_oe,
  .led_status, .phy_address, .partner_remote_fault, .link_is_10base_t, .tx_activity,
  .rx_activity, .carrier_sense, .sqe_test_default, .pair_tx_positive_oe,
  .pair_tx_negative_oe, .tx100_power_down);

// ---- bench/board_model.sv ----
// Purpose: Board around the PHY: strap resistors and shared LED pins.
// Assumes: Every shared pin has a resistor to the level in PULL.
// Notes:   A released pin shows the resistor, never the last drive.
`timescale 1ns/10ps
module board_model
  import ext_ctl_two_pkg::*;
#(
  parameter logic               PRIO = 1'b1,   // Register priority strap
  parameter logic [NUM_LED-1:0] PULL = 5'h15   // Resistor levels
) (
  input  wire logic               node_strap_level, // Jumper level, moved only in reset
  input  wire logic [NUM_LED-1:0] led_pin_out,
  input  wire logic [NUM_LED-1:0] led_pin_oe,
  output logic                    node_repeater_strap,
  output logic                    pin_or_register_priority_strap,
  output logic [NUM_LED-1:0]      led_pin_in
);
  // Priority strap is soldered; node strap is a jumper the bench sets
  assign node_repeater_strap            = node_strap_level;
  assign pin_or_register_priority_strap = PRIO;
  // Wire level from the driver enable and the resistor
  always_comb begin
    for (int i = 0; i < NUM_LED; i++) begin
      led_pin_in[i] = led_pin_oe[i] ? led_pin_out[i] : PULL[i];
    end
  end
endmodule // board_model

// ---- bench/phy_extended_control_two_tb.sv ----
// Purpose: Self-checking bench for the second extended control register.
// Assumes: Repeater strap first, node strap after a mid-run reset.
// Notes:   Bus tasks drive on the rising edge only.
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module phy_extended_control_two_tb
  import ext_ctl_two_pkg::*;
;
  localparam logic [NUM_LED-1:0] PULL = 5'h15;  // Resistors on shared pins
  logic              clock = 0, rst_n = 0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
  logic              reg_write = 0, reg_read = 0, irq;
  logic              node_repeater_strap, pin_or_register_priority_strap;
  logic              node_strap_level = 1;  // Repeater until the second reset
  logic [NUM_LED-1:0] led_pin_in, led_pin_out, led_pin_oe, phy_address;
  logic [NUM_LED-1:0] led_status = '0;
  logic              partner_remote_fault = 0, link_is_10base_t = 0;
  logic              tx_activity = 0, rx_activity = 0, carrier_sense, sqe_test_default;
  logic              tx_positive_data = 0, tx_negative_data = 0;
  logic              pair_tx_positive, pair_tx_positive_oe, pair_tx_negative;
  logic              pair_tx_negative_oe, tx100_power_down;
  int                fail_count = 0, n_checks = 0, cycles = 0;

  always #25 clock = ~clock;  // 20 MHz

  phy_extended_control_two u_phy_extended_control_two (.clock, .rst_n, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq, .node_repeater_strap,
    .pin_or_register_priority_strap, .led_pin_in, .led_pin_out, .led_pin_oe, .led_status,
    .phy_address, .partner_remote_fault, .link_is_10base_t, .tx_activity, .rx_activity,
    .carrier_sense, .sqe_test_default, .tx_positive_data, .tx_negative_data,
    .pair_tx_positive, .pair_tx_positive_oe, .pair_tx_negative, .pair_tx_negative_oe,
    .tx100_power_down);
  board_model #(.PULL(PULL)) u_board_model (.node_strap_level, .led_pin_out, .led_pin_oe,
    .node_repeater_strap, .pin_or_register_priority_strap, .led_pin_in);

  // Strobes idle for n edges
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clock);
      reg_write <= 0;
      reg_read  <= 0;
    end
  endtask
  // Idle, then step off the edge to sample settled outputs
  task automatic look(input int n);
    idle(n);
    #1;
  endtask
  // One-cycle write; the next task or idle drops the strobe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    reg_addr <= a; reg_wdata <= d; reg_write <= 1; reg_read <= 0;
  endtask
  // One-cycle read; data is only valid in the following cycle
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clock);
    reg_addr <= a; reg_read <= 1; reg_write <= 0;
    @(posedge clock);
    reg_read <= 0;
    #1;
    `CHK(reg_rdata, exp)
  endtask

  task automatic final_report;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Hang guard, well above the 66 or so cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1;
    idle(3);
    rd(REG_EXT_CTL2, 16'hC001);
    wr(REG_EXT_CTL2, 16'hE0A0);
    rd(REG_EXT_CTL2, 16'hC0A0);
    look(2);
    `CHK({pair_tx_positive_oe, pair_tx_negative_oe}, 2'b00)
    `CHK(led_pin_out, ~PULL)
    `CHK(phy_address, PULL)
    wr(REG_EXT_CTL2, 16'h0001);
    wr(5'h02, 16'hFFFF);
    rd(5'h02, 16'h0000);
    rd(REG_EXT_CTL2, 16'hC001);
    idle(1);
    led_status <= 5'h03; tx_positive_data <= 1; rx_activity <= 1; link_is_10base_t <= 1;
    look(3);
    `CHK(led_pin_out, PULL ^ 5'h03)
    `CHK({pair_tx_positive_oe, pair_tx_positive, pair_tx_negative}, 3'b110)
    `CHK({carrier_sense, sqe_test_default, tx100_power_down}, 3'b101)
    idle(1);
    rx_activity <= 0; tx_activity <= 1; link_is_10base_t <= 0;
    look(3);
    `CHK({carrier_sense, tx100_power_down}, 2'b00)
    wr(REG_IRQ_MASK, 16'h0001);
    partner_remote_fault <= 1;
    look(3);
    `CHK(irq, 1'b1)
    rd(REG_IRQ_STAT, 16'h0001);
    rd(REG_EXT_CTL2, 16'hE001);
    wr(REG_IRQ_STAT, 16'h0001);
    look(2);
    `CHK(irq, 1'b0)
    idle(1);
    partner_remote_fault <= 0;
    look(3);
    `CHK(irq, 1'b0)
    rd(REG_IRQ_STAT, 16'h0002);
    wr(REG_IRQ_MASK, 16'h0003);
    look(2);
    `CHK(irq, 1'b1)
    wr(REG_IRQ_STAT, 16'h0002);
    rd(REG_IRQ_MASK, 16'h0003);
    look(1);
    `CHK(irq, 1'b0)
    // Second reset with the node strap: own transmit now raises carrier
    idle(1);
    rst_n <= 0; node_strap_level <= 0;
    idle(6);
    rst_n <= 1;
    look(3);
    `CHK({carrier_sense, sqe_test_default}, 2'b11)
    rd(REG_EXT_CTL2, 16'h4001);
    final_report();
  end
endmodule // phy_extended_control_two_tb
